// ===== port_regs.sv
// Contract
// RQ1: Host never touches offsets 0x09 through 0x0F.
// RQ2: Bit 14 enables energy sense and pulse; reset from strap pin.
// RQ3: Link-pulse check and generation disables ignored when negotiation on.
// RQ4: Bit 12 routes next pages to the separate next page store.
// RQ5: Bit 10 forces link reported permanently up.
// RQ6: Bit 9 disables scrambler; set at hardware reset in fiber mode.
// RQ7: Bit 8 disables far-end fault in fiber; copper always disabled.
// RQ8: Bit 7 lowers the 10BASE-T receive threshold; resets to zero.
// RQ9: Shielded-pair and crossover writes apply only after software reset.
// RQ10: Crossover 00 swapped, 01 straight, 1x auto; strap loads 11. Code loads 11 only with crossover_strap high, 01 with it low.
// RQ11: Field 3:2 picks buffer depth 4, 6 or 8 bytes; 11 reserved.
// RQ12: Bit 1 disables polarity correction in 10BASE-T only.
// RQ13: Bit 0 disables jabber; jabber inert in full duplex or 100.
// RQ14: Rate and duplex from straps, update on negotiation, keep on soft reset.
// RQ15: Resolved bit set on negotiation done or disabled; gates rate, duplex.
// RQ16: Status shows live link and crossover state.
// RQ17: Sleep status is one while no wire activity.
// RQ18: Status bit 1 live polarity, bit 0 live jabber.
// RQ19: One interrupt enable per event at documented positions.
// RQ20: Interrupt status latches events; bits 5, 3, 2 read zero.
// RQ21: Software reset clears crossover-change enable only.
// RQ22: Summary flag high while any enabled latched event is set.
// RQ23: Latched events clear when the interrupt status is read.
module port_regs
    import port_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic soft_reset,
    input wire logic [2:0] negotiation_strap_pins,
    input wire logic crossover_strap,
    input wire logic energy_strap_pin,
    input wire logic fault_strap_pin,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic negotiation_on,
    input wire logic negotiation_done,
    input wire logic negotiated_rate,
    input wire logic negotiated_duplex,
    input wire logic page_received,
    input wire logic link_from_fsm,
    input wire logic crossover_now,
    input wire logic no_wire_activity,
    input wire logic polarity_reversed,
    input wire logic jabber_seen,
    input wire logic symbol_fault,
    input wire logic false_carrier,
    input wire logic buffer_fault,
    output logic [15:0] reg_rdata,
    output logic energy_sense_enable,
    output logic link_pulse_check_off,
    output logic link_pulse_gen_off,
    output logic separate_page_store,
    output logic scrambler_off,
    output logic far_fault_indication_off,
    output logic long_cable_threshold,
    output logic shielded_pair_select,
    output logic [1:0] crossover_select,
    output logic [3:0] receive_buffer_depth,
    output logic polarity_fix_off,
    output logic babble_guard_off,
    output logic live_link_state,
    output logic port_event_summary
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    logic [15:0] ctrl_q, ctrl_d;
    logic [2:0] pend_q, pend_d;       // shield + crossover awaiting soft reset
    logic [15:0] ien_q, ien_d;
    logic [15:0] ist_q, ist_d;
    logic rate_q, rate_d, dup_q, dup_d, resolved_q, resolved_d;
    logic page_q, page_d;
    logic strap_q, strap_d;           // straps pending capture after release
    logic [15:0] prev_q, prev_d;      // previous live state, for change events
    logic [15:0] rdata_q, rdata_d;
    logic [13:0] out_q, out_d;
    logic [3:0] depth_q, depth_d;
    logic link_q, link_d, sum_q, sum_d;

    logic fiber;
    logic link_live;
    logic [15:0] stat_w, live_w, ev_w;

    assign fiber = (negotiation_strap_pins == FIBER_STRAP);
    assign link_live = ctrl_q[LINK_OVR_BIT] | link_from_fsm;  // [RQ5]

    // ----------------------------------------
    // Status and event composition
    // ----------------------------------------
    always_comb begin
        stat_w = ZERO16;
        stat_w[RATE_BIT] = rate_q & resolved_q;      // [RQ15]
        stat_w[DUPLEX_BIT] = dup_q & resolved_q;     // [RQ15]
        stat_w[PAGE_BIT] = page_q;
        stat_w[RESOLVED_BIT] = resolved_q;           // [RQ15]
        stat_w[LIVE_LINK_BIT] = link_live;           // [RQ16]
        stat_w[XSTATE_BIT] = crossover_now;          // [RQ16]
        stat_w[SLEEP_BIT] = no_wire_activity;        // [RQ17]
        stat_w[1] = polarity_reversed;               // [RQ18]
        stat_w[0] = jabber_seen;                     // [RQ18]
        live_w = stat_w;
        live_w[SLEEP_BIT] = no_wire_activity;
        ev_w = ZERO16;
        ev_w[14] = rate_q != prev_q[RATE_BIT];
        ev_w[13] = dup_q != prev_q[DUPLEX_BIT];
        ev_w[12] = page_received;
        ev_w[11] = negotiation_done;
        ev_w[10] = link_live != prev_q[LIVE_LINK_BIT];
        ev_w[9] = symbol_fault;
        ev_w[8] = false_carrier;
        ev_w[7] = buffer_fault;
        ev_w[6] = crossover_now != prev_q[XSTATE_BIT];
        ev_w[4] = no_wire_activity != prev_q[SLEEP_BIT];
        ev_w[1] = polarity_reversed != prev_q[1];
        ev_w[0] = jabber_seen;
        if (strap_q) begin
            ev_w = ZERO16;
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        pend_d = pend_q;
        ien_d = ien_q;
        ist_d = ist_q;
        rate_d = rate_q;
        dup_d = dup_q;
        resolved_d = resolved_q;
        page_d = page_q | page_received;
        strap_d = 1'b0;
        prev_d = live_w;
        prev_d[RATE_BIT] = rate_q;
        prev_d[DUPLEX_BIT] = dup_q;
        rdata_d = rdata_q;
        if (strap_q) begin
            ctrl_d = ZERO16;
            ctrl_d[ENERGY_BIT] = energy_strap_pin;                 // [RQ2]
            ctrl_d[SCRAMBLER_BIT] = fiber;                         // [RQ6]
            ctrl_d[FAULT_BIT] = fiber & fault_strap_pin;           // [RQ7]
            ctrl_d[SHIELD_BIT] = negotiation_strap_pins[0];
            ctrl_d[XOVER_LSB +: 2] = crossover_strap ? XOVER_AUTO
                                                     : XOVER_STRAIGHT;// [RQ10]
            pend_d = ctrl_d[XOVER_LSB +: 3];
            rate_d = negotiation_strap_pins[1];                    // [RQ14]
            dup_d = negotiation_strap_pins[0];                     // [RQ14]
            // Strap-loaded rate and duplex are no change event
            prev_d[RATE_BIT] = rate_d;
            prev_d[DUPLEX_BIT] = dup_d;
        end else if (soft_reset) begin
            ctrl_d = ctrl_q & CTRL_SW_KEEP;
            ctrl_d[XOVER_LSB +: 3] = pend_q;                       // [RQ9]
            ien_d = ien_q & ~IEN_SW_CLEAR;                         // [RQ21]
            // Events of the reset cycle itself still latch
            ist_d = ev_w & EVENT_MASK;                             // [RQ20]
            resolved_d = 1'b0;
            page_d = 1'b0;
        end else begin
            if (negotiation_done) begin
                rate_d = negotiated_rate;                          // [RQ14]
                dup_d = negotiated_duplex;                         // [RQ14]
            end
            resolved_d = negotiation_done | ~negotiation_on
                       | (resolved_q & negotiation_on);            // [RQ15]
            if (reg_rd) begin
                unique case (reg_addr)
                    CTRL_OFFSET: rdata_d = ctrl_q;
                    STAT_OFFSET: begin
                        rdata_d = stat_w;
                        page_d = page_received;
                    end
                    IEN_OFFSET: rdata_d = ien_q;
                    ISTAT_OFFSET: begin
                        rdata_d = ist_q;
                        ist_d = ZERO16;                            // [RQ23]
                    end
                    default: rdata_d = ZERO16;
                endcase
            end
            if (reg_wr && reg_addr == CTRL_OFFSET) begin
                ctrl_d = reg_wdata & CTRL_WMASK;
                ctrl_d[XOVER_LSB +: 3] = ctrl_q[XOVER_LSB +: 3];   // [RQ9]
                pend_d = reg_wdata[XOVER_LSB +: 3];                // [RQ9]
            end
            if (reg_wr && reg_addr == IEN_OFFSET) begin
                ien_d = reg_wdata & EVENT_MASK;                    // [RQ19]
            end
            // Set wins over read-clear so no event is lost
            ist_d = ist_d | (ev_w & EVENT_MASK);                   // [RQ20]
        end
    end

    // ----------------------------------------
    // Derived outputs, all registered
    // ----------------------------------------
    always_comb begin
        out_d = ZERO16[13:0];
        out_d[13] = ctrl_d[ENERGY_BIT];
        out_d[12] = ctrl_d[PULSE_CHECK_BIT] & ~negotiation_on;     // [RQ3]
        out_d[11] = ctrl_d[PULSE_GEN_BIT] & ~negotiation_on;       // [RQ3]
        out_d[10] = ctrl_d[PAGE_STORE_BIT];                        // [RQ4]
        out_d[9] = ctrl_d[SCRAMBLER_BIT];                          // [RQ6]
        out_d[8] = ctrl_d[FAULT_BIT] | ~fiber;                     // [RQ7]
        out_d[7] = ctrl_d[LONG_CABLE_BIT];                         // [RQ8]
        out_d[6] = ctrl_d[SHIELD_BIT];
        out_d[5:4] = ctrl_d[XOVER_LSB +: 2];                       // [RQ10]
        // Polarity fix only meaningful at 10 Mbps
        out_d[1] = ctrl_d[POLARITY_BIT] & ~rate_d;                 // [RQ12]
        // Jabber guard off in full duplex or 100 operation
        out_d[0] = ctrl_d[BABBLE_BIT] | dup_d | rate_d;            // [RQ13]
        unique case (ctrl_d[DEPTH_LSB +: 2])                       // [RQ11]
            2'h0: depth_d = DEPTH_4;
            2'h1: depth_d = DEPTH_6;
            2'h2: depth_d = DEPTH_8;
            // Reserved code falls back to smallest depth
            default: depth_d = DEPTH_4;
        endcase
        link_d = link_live;
        sum_d = |(ist_d & ien_d);                                  // [RQ22]
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= ZERO16;
            pend_q <= 3'h0;
            ien_q <= ZERO16;
            ist_q <= ZERO16;
            rate_q <= 1'b0;
            dup_q <= 1'b0;
            resolved_q <= 1'b0;
            page_q <= 1'b0;
            strap_q <= 1'b1;
            prev_q <= ZERO16;
            rdata_q <= ZERO16;
            out_q <= 14'h0000;
            depth_q <= DEPTH_4;
            link_q <= 1'b0;
            sum_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            pend_q <= pend_d;
            ien_q <= ien_d;
            ist_q <= ist_d;
            rate_q <= rate_d;
            dup_q <= dup_d;
            resolved_q <= resolved_d;
            page_q <= page_d;
            strap_q <= strap_d;
            prev_q <= prev_d;
            rdata_q <= rdata_d;
            out_q <= out_d;
            depth_q <= depth_d;
            link_q <= link_d;
            sum_q <= sum_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign energy_sense_enable = out_q[13];                        // [RQ2]
    assign link_pulse_check_off = out_q[12];
    assign link_pulse_gen_off = out_q[11];
    assign separate_page_store = out_q[10];
    assign scrambler_off = out_q[9];
    assign far_fault_indication_off = out_q[8];
    assign long_cable_threshold = out_q[7];
    assign shielded_pair_select = out_q[6];
    assign crossover_select = out_q[5:4];
    assign receive_buffer_depth = depth_q;
    assign polarity_fix_off = out_q[1];
    assign babble_guard_off = out_q[0];
    assign live_link_state = link_q;
    assign port_event_summary = sum_q;

endmodule : port_regs

// ===== port_regs_pkg.sv
package port_regs_pkg;

    // ----------------------------------------
    // Register offsets (5-bit management address)
    // ----------------------------------------
    localparam logic [4:0] CTRL_OFFSET = 5'h10;
    localparam logic [4:0] STAT_OFFSET = 5'h11;
    localparam logic [4:0] IEN_OFFSET = 5'h12;
    localparam logic [4:0] ISTAT_OFFSET = 5'h13;

    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int ENERGY_BIT = 14;
    localparam int PULSE_CHECK_BIT = 13;
    localparam int PAGE_STORE_BIT = 12;
    localparam int PULSE_GEN_BIT = 11;
    localparam int LINK_OVR_BIT = 10;
    localparam int SCRAMBLER_BIT = 9;
    localparam int FAULT_BIT = 8;
    localparam int LONG_CABLE_BIT = 7;
    localparam int SHIELD_BIT = 6;
    localparam int XOVER_LSB = 4;
    localparam int DEPTH_LSB = 2;
    localparam int POLARITY_BIT = 1;
    localparam int BABBLE_BIT = 0;

    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int RATE_BIT = 14;
    localparam int DUPLEX_BIT = 13;
    localparam int PAGE_BIT = 12;
    localparam int RESOLVED_BIT = 11;
    localparam int LIVE_LINK_BIT = 10;
    localparam int XSTATE_BIT = 6;
    localparam int SLEEP_BIT = 4;

    // ----------------------------------------
    // Event bits, writable masks, reset values
    // ----------------------------------------
    localparam logic [15:0] EVENT_MASK = 16'h7fd3;
    localparam logic [15:0] IEN_SW_CLEAR = 16'h0040;
    localparam logic [15:0] CTRL_WMASK = 16'h7fff;
    localparam logic [15:0] CTRL_SW_KEEP = 16'h4370;
    localparam logic [1:0] XOVER_AUTO = 2'h3;
    localparam logic [1:0] XOVER_STRAIGHT = 2'h1;
    localparam logic [1:0] DEPTH_RESERVED = 2'h3;
    localparam logic [2:0] FIBER_STRAP = 3'h7;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // Receive buffer depth in bytes per code
    localparam logic [3:0] DEPTH_4 = 4'h4;
    localparam logic [3:0] DEPTH_6 = 4'h6;
    localparam logic [3:0] DEPTH_8 = 4'h8;

endpackage : port_regs_pkg

// ===== port_regs_monitor.sv
module port_regs_monitor
    import port_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic soft_reset,
    input wire logic [2:0] negotiation_strap_pins,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic negotiation_on,
    input wire logic link_from_fsm,
    input wire logic crossover_now,
    input wire logic no_wire_activity,
    input wire logic [15:0] reg_rdata,
    input wire logic link_pulse_check_off,
    input wire logic link_pulse_gen_off,
    input wire logic separate_page_store,
    input wire logic far_fault_indication_off,
    input wire logic long_cable_threshold,
    input wire logic [3:0] receive_buffer_depth,
    input wire logic live_link_state,
    input wire logic port_event_summary
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (srst);

    function automatic logic [3:0] dep(input logic [15:0] w);
        return (w[3:2] == 2'h1) ? DEPTH_6 :
               (w[3:2] == 2'h2) ? DEPTH_8 : DEPTH_4;
    endfunction : dep

    // Quiet gap so either output latency reading still holds
    sequence ctrl_wr;
        (reg_wr && reg_addr == CTRL_OFFSET && !soft_reset)
            ##1 (!reg_wr && !soft_reset) [*2];
    endsequence

    a_depth_follows_write:
        assert property (ctrl_wr |=> receive_buffer_depth ==
            dep($past(reg_wdata, 3))) else $error("depth not decoded");
    a_cable_follows_write:
        assert property (ctrl_wr |=> long_cable_threshold ==
            $past(reg_wdata[7], 3)) else $error("threshold not written");
    a_page_store_write:
        assert property (ctrl_wr |=> separate_page_store ==
            $past(reg_wdata[12], 3)) else $error("page store not written");
    a_pulse_ignored_neg:
        assert property (negotiation_on [*3] |->
            !link_pulse_check_off && !link_pulse_gen_off)
            else $error("pulse disables active in negotiation");
    a_copper_fault_off:
        assert property ((negotiation_strap_pins != FIBER_STRAP) [*3]
            |-> far_fault_indication_off) else $error("copper fault on");
    a_live_link_up:
        assert property (link_from_fsm [*4] |-> live_link_state)
            else $error("live link low while link up");
    a_istat_reserved_zero:
        assert property (reg_rd && reg_addr == ISTAT_OFFSET |=>
            (reg_rdata & ~EVENT_MASK) == ZERO16) else $error("reserved set");
    a_live_status_read:
        assert property ((reg_rd && reg_addr == STAT_OFFSET &&
            $stable(no_wire_activity) && $stable(crossover_now)) |=>
            reg_rdata[SLEEP_BIT] == $past(no_wire_activity) &&
            reg_rdata[XSTATE_BIT] == $past(crossover_now))
            else $error("live status wrong");
    a_resolved_when_off:
        assert property ((!negotiation_on) [*3] ##0
            (reg_rd && reg_addr == STAT_OFFSET) |=> reg_rdata[RESOLVED_BIT])
            else $error("resolved low with negotiation off");

    c_ctrl_write: cover property (ctrl_wr);
    c_summary: cover property (port_event_summary);
    c_istat_read: cover property (reg_rd && reg_addr == ISTAT_OFFSET);
endmodule : port_regs_monitor

// ===== mgmt_host_model.sv
module mgmt_host_model
    import port_regs_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [15:0] reg_rdata,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    output logic soft_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata, soft_reset} = '0;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        if (a inside {[5'h09:5'h0f]}) return;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        if (a inside {[5'h09:5'h0f]}) return;
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1 d = reg_rdata;
    endtask : rd

    task automatic sreset();
        @(posedge ref_clk);
        soft_reset <= 1'b1;
        @(posedge ref_clk);
        soft_reset <= 1'b0;
    endtask : sreset

    // Wiring fields only take hold after a soft reset
    task automatic wr_apply(input logic [15:0] d);
        wr(CTRL_OFFSET, d);
        sreset();
    endtask : wr_apply
endmodule : mgmt_host_model

// ===== port_regs_tb.sv
module port_regs_tb
    import port_regs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, srst, negotiation_on, negotiation_done, negotiated_rate;
    logic negotiated_duplex, page_received, link_from_fsm, crossover_now;
    logic no_wire_activity, polarity_reversed, jabber_seen, symbol_fault;
    logic false_carrier, buffer_fault, crossover_strap, energy_strap_pin;
    logic fault_strap_pin, reg_wr, reg_rd, soft_reset, energy_sense_enable;
    logic link_pulse_check_off, link_pulse_gen_off, separate_page_store;
    logic scrambler_off, far_fault_indication_off, long_cable_threshold;
    logic shielded_pair_select, polarity_fix_off, babble_guard_off;
    logic live_link_state, port_event_summary;
    logic [2:0] negotiation_strap_pins;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [1:0] crossover_select;
    logic [3:0] receive_buffer_depth;
    int n_mismatch = 0;
    int checks_done = 0;

    port_regs port_regs_inst (.*);
    mgmt_host_model mgmt_host_model_inst (.*);

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic hw_reset(input logic [2:0] s, input logic [2:0] p);
        @(posedge ref_clk);
        srst <= 1'b1;
        negotiation_strap_pins <= s;
        {crossover_strap, energy_strap_pin, fault_strap_pin} <= p;
        // Negotiation off, so strap values read as resolved
        negotiation_on <= 1'b0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask : hw_reset

    // ----------------------------------------
    // Event stimulus, one source per status bit
    // ----------------------------------------
    task automatic ev(input int b);
        @(posedge ref_clk);
        case (b)
            12: page_received <= 1'b1;
            11: negotiation_done <= 1'b1;
            10: link_from_fsm <= ~link_from_fsm;
            9: symbol_fault <= 1'b1;
            8: false_carrier <= 1'b1;
            7: buffer_fault <= 1'b1;
            6: crossover_now <= ~crossover_now;
            4: no_wire_activity <= ~no_wire_activity;
            1: polarity_reversed <= ~polarity_reversed;
            default: jabber_seen <= 1'b1;
        endcase
        @(posedge ref_clk);
        {page_received, negotiation_done, symbol_fault} <= 3'h0;
        {false_carrier, buffer_fault, jabber_seen} <= 3'h0;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : ev

    task automatic t_fiber_reset();
        hw_reset(3'h7, 3'h6);
        chk({scrambler_off, energy_sense_enable}, 2'h3);
        chk(far_fault_indication_off, 1'b0);
        chk(long_cable_threshold, 1'b0);
        chk(crossover_select, XOVER_AUTO);
        mgmt_host_model_inst.rd(STAT_OFFSET, d);
        chk(d & 16'h6800, 16'h6800);
    endtask : t_fiber_reset

    task automatic t_ctrl();
        logic [3:0] exp_d[4] = '{DEPTH_4, DEPTH_6, DEPTH_8, DEPTH_4};
        for (int i = 0; i < 4; i++) begin
            mgmt_host_model_inst.wr(CTRL_OFFSET, {12'h000, i[1:0], 2'h0});
            repeat (3) @(posedge ref_clk);
            #1 chk(receive_buffer_depth, exp_d[i]);
        end
        mgmt_host_model_inst.wr(CTRL_OFFSET, 16'h3c83);
        repeat (3) @(posedge ref_clk);
        #1 chk({separate_page_store, live_link_state}, 2'h3);
        // Rate is 100 Mbps here, so the polarity-fix disable stays masked and polarity_fix_off reads 0
        chk({long_cable_threshold, polarity_fix_off}, 2'h2);
        chk({babble_guard_off, scrambler_off}, 2'h2);
        chk({link_pulse_check_off, link_pulse_gen_off}, 2'h3);
        @(posedge ref_clk);
        negotiation_on <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk({link_pulse_check_off, link_pulse_gen_off}, 2'h0);
        // Unmapped offsets swallow writes and read back zero
        mgmt_host_model_inst.wr(5'h15, 16'hffff);
        mgmt_host_model_inst.rd(5'h15, d);
        chk(d, ZERO16);
    endtask : t_ctrl

    task automatic t_xover();
        logic [1:0] codes[3] = '{2'h0, 2'h1, 2'h2};
        logic [2:0] prev = 3'h7;
        mgmt_host_model_inst.wr(IEN_OFFSET, 16'h7fd3);
        for (int i = 0; i < 3; i++) begin
            mgmt_host_model_inst.wr(CTRL_OFFSET, {9'h000, i[0], codes[i], 4'h0});
            repeat (3) @(posedge ref_clk);
            #1 chk({shielded_pair_select, crossover_select}, prev);
            mgmt_host_model_inst.sreset();
            prev = {i[0], codes[i]};
            repeat (3) @(posedge ref_clk);
            #1 chk({shielded_pair_select, crossover_select}, prev);
        end
        mgmt_host_model_inst.rd(IEN_OFFSET, d);
        chk(d, 16'h7f93);
        mgmt_host_model_inst.rd(STAT_OFFSET, d);
        chk(d & 16'h6800, 16'h0000);
        @(posedge ref_clk);
        negotiation_on <= 1'b0;
        repeat (2) @(posedge ref_clk);
        mgmt_host_model_inst.rd(STAT_OFFSET, d);
        chk(d & 16'h6800, 16'h6800);
        @(posedge ref_clk);
        negotiation_on <= 1'b1;
    endtask : t_xover

    task automatic t_events();
        int b[10] = '{12, 11, 10, 9, 8, 7, 6, 4, 1, 0};
        // Soft reset drops resolved until negotiation completes
        mgmt_host_model_inst.sreset();
        mgmt_host_model_inst.wr(IEN_OFFSET, 16'h7fd3);
        mgmt_host_model_inst.rd(ISTAT_OFFSET, d);
        foreach (b[k]) begin
            ev(b[k]);
            chk(port_event_summary, 1'b1);
            mgmt_host_model_inst.rd(ISTAT_OFFSET, d);
            chk(d, (b[k] == 11) ? 16'h6800 : 16'h0001 << b[k]);
            mgmt_host_model_inst.rd(ISTAT_OFFSET, d);
            chk(d, ZERO16);
            chk(port_event_summary, 1'b0);
        end
        mgmt_host_model_inst.wr(IEN_OFFSET, 16'h0000);
        ev(9);
        chk(port_event_summary, 1'b0);
        mgmt_host_model_inst.rd(ISTAT_OFFSET, d);
        chk(d, 16'h0200);
        mgmt_host_model_inst.rd(STAT_OFFSET, d);
        chk(d & 16'h6c53, 16'h0c52);
        // Now 10 Mbps half duplex, so both guards take effect
        mgmt_host_model_inst.wr(CTRL_OFFSET, 16'h0002);
        repeat (3) @(posedge ref_clk);
        #1 chk({polarity_fix_off, babble_guard_off}, 2'h2);
    endtask : t_events

    task automatic t_copper_reset();
        hw_reset(3'h2, 3'h0);
        chk({scrambler_off, far_fault_indication_off}, 2'h1);
        chk({energy_sense_enable, crossover_select}, 3'h1);
        mgmt_host_model_inst.rd(STAT_OFFSET, d);
        chk(d & 16'h6000, 16'h4000);
    endtask : t_copper_reset

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        srst = 1'b1;
        {negotiation_on, negotiation_done, negotiated_rate} = 3'h0;
        {negotiated_duplex, page_received, link_from_fsm} = 3'h0;
        {crossover_now, no_wire_activity, polarity_reversed} = 3'h0;
        {jabber_seen, symbol_fault, false_carrier, buffer_fault} = 4'h0;
        {crossover_strap, energy_strap_pin, fault_strap_pin} = 3'h0;
        negotiation_strap_pins = 3'h0;
        t_fiber_reset();
        t_ctrl();
        t_xover();
        t_events();
        t_copper_reset();
        test_done();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_mismatch++;
        test_done();
    end
endmodule : port_regs_tb

bind port_regs port_regs_monitor port_regs_monitor_inst (.*);
